/* File: bench/rcs_chk_sva.sv */
module rcs_chk
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // watched ports
  input wire rcs_cfg_wr_t cfg_wr,
  input wire logic        frame_sync,
  input wire rcs_frame_t  out_frame,
  input wire logic [1:0]  channel_sum_select,
  input wire logic [1:0]  decimation_type_select
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire hit = cfg_wr.wr && cfg_wr.page == CFG_PAGE && cfg_wr.addr == CFG_REG;
  sequence s_rise; $rose(frame_sync); endsequence
  sequence s_out; ##[2:6] out_frame.valid; endsequence
  property p_sum; hit |=> channel_sum_select == $past(cfg_wr.data[3:2]);
  endproperty
  property p_dec; hit |=> decimation_type_select == $past(cfg_wr.data[5:4]);
  endproperty
  property p_hold;
    !hit |=> $stable({channel_sum_select, decimation_type_select});
  endproperty
  property p_rst;
    $rose(arst_n) |-> channel_sum_select == 2'h0 && !decimation_type_select;
  endproperty
  property p_frame; s_rise |-> s_out; endproperty
  property p_pulse; out_frame.valid |=> !out_frame.valid; endproperty
  property p_stand; !out_frame.valid |-> $stable(out_frame.ch); endproperty
  property p_pair; out_frame.valid && channel_sum_select == SUM_PAIR |->
    out_frame.ch[0] == out_frame.ch[1] && out_frame.ch[4] == out_frame.ch[5];
  endproperty
  property p_quad; out_frame.valid && channel_sum_select == SUM_QUAD |->
    out_frame.ch[0] == out_frame.ch[1] && out_frame.ch[2] == out_frame.ch[3];
  endproperty
  a_sum: assert property (p_sum) else $error("sum select");
  a_dec: assert property (p_dec) else $error("dec select");
  a_hold: assert property (p_hold) else $error("select moved");
  a_rst: assert property (p_rst) else $error("reset select");
  a_frame: assert property (p_frame) else $error("no sample");
  a_pulse: assert property (p_pulse) else $error("long valid");
  a_stand: assert property (p_stand) else $error("ch moved");
  a_pair: assert property (p_pair) else $error("pair");
  a_quad: assert property (p_quad) else $error("quad");
endmodule // rcs_chk

bind rcs_record_path rcs_chk u_chk (.clock(clock), .arst_n(arst_n),
  .cfg_wr(cfg_wr), .frame_sync(frame_sync), .out_frame(out_frame),
  .channel_sum_select(channel_sum_select),
  .decimation_type_select(decimation_type_select));

/* File: bench/rcs_fs_model.sv */
module rcs_fs_model #(
  parameter int PERIOD = 8
) (
  // clock and run control
  input wire logic clock,
  input wire logic run,
  // frame timing toward the block
  output logic     frame_sync,
  output logic     mod_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial frame_sync = 1'b0;
  initial mod_valid = 1'b0;
  // stopped means no ticks and a low sync, so no stray frames
  always @(posedge clock) begin
    #1;
    cnt = run ? (cnt + 1) % PERIOD : 0;
    frame_sync = run && cnt >= PERIOD / 2;
    mod_valid = run;
  end
endmodule // rcs_fs_model

/* File: bench/rcs_record_path_tb.sv */
`define CHK(g, e) chk(64'(g), 64'(e));
module rcs_record_path_tb
  import rcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [NCH_IN-1:0][SMP_W-1:0] XS = {24'h000005, 24'h0003E8,
    24'hFFFFF7, 24'h000007, 24'h00012C, 24'hFFFF9C};
  localparam logic [7:0] BP [4] = '{8'h02, 8'h02, 8'h03, 8'h03};
  localparam logic [6:0] BA [4] = '{7'h08, 7'h7F, 7'h08, 7'h7F};
  localparam logic [7:0] BD [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
  localparam logic [7:0] BI [4] = '{8'h00, 8'h77, 8'h78, 8'hEF};
  logic                         clock = 1'b0, arst_n = 1'b0, run = 1'b0;
  logic                         mix_enable = 1'b0, pdm_select = 1'b0;
  rcs_cfg_wr_t                  cfg_wr = '0;
  logic [3:0][3:0][COEF_W-1:0]  mix_gain = '0;
  logic [NCH_IN-1:0][SMP_W-1:0] mod_data = XS;
  logic [5:0]                   pdm_bits = 6'h15;
  logic [7:0]                   bq_rd_idx = 8'h00, bq_rd_data;
  logic                         mod_valid, frame_sync;
  rcs_frame_t                   out_frame;
  logic [1:0]                   sum_sel, dec_sel;
  int                           mismatches = 0, checks_done = 0, la [4];
  always #25 clock = ~clock;
  rcs_fs_model #(.PERIOD(8)) u_fs (.clock(clock), .run(run),
    .frame_sync(frame_sync), .mod_valid(mod_valid));
  rcs_record_path #(.OVERSAMPLE(8)) DUT (.clock(clock), .arst_n(arst_n),
    .cfg_wr(cfg_wr), .mix_gain(mix_gain), .mix_enable(mix_enable),
    .mod_valid(mod_valid), .mod_data(mod_data), .pdm_select(pdm_select),
    .pdm_bits(pdm_bits), .frame_sync(frame_sync), .out_frame(out_frame),
    .channel_sum_select(sum_sel), .decimation_type_select(dec_sel),
    .bq_rd_idx(bq_rd_idx), .bq_rd_data(bq_rd_data));
  task automatic chk(logic [63:0] g, logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wr(logic [7:0] p, logic [6:0] a, logic [7:0] d);
    cfg_wr = '{page: p, addr: a, data: d, wr: 1'b1};
    tick();
    // an idle edge between writes keeps the strobe from being set twice
    cfg_wr.wr = 1'b0;
    tick();
  endtask
  task automatic frames(int n);
    int w;
    repeat (n) begin
      w = 0;
      do begin tick(); w++; end while (out_frame.valid !== 1'b1 && w < 99);
      if (w >= 99) mismatches++;
    end
  endtask
  // a reset clears the frame delay line, so no old mode leaks out
  task automatic restart(logic [7:0] cfg);
    run = 1'b0;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick();
    wr(CFG_PAGE, CFG_REG, cfg);
    run = 1'b1;
    frames(24);
  endtask
  function automatic longint sx(int i);
    return longint'($signed(XS[i]));
  endfunction
  function automatic logic [SMP_W-1:0] expect_ch(logic [1:0] m, int i);
    longint a;
    a = sx(i);
    if (m == SUM_PAIR) a = (sx(i & 6) + sx(i | 1)) >>> 1;
    if (m == SUM_QUAD && i < 4) a = (sx(0) + sx(1) + sx(2) + sx(3)) >>> 2;
    if (m == SUM_OFF && mix_enable && i < 4) begin
      a = 0;
      for (int k = 0; k < 4; k++) a += sx(k) * $signed(mix_gain[i][k]);
      a = a >>> 15;
    end
    return a[SMP_W-1:0];
  endfunction
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    mix_gain[0][0] = 16'h4000;
    mix_gain[0][3] = 16'h2000;
    mix_gain[1][1] = 16'h4000;
    mix_gain[2][2] = 16'h6000;
    mix_gain[3][3] = 16'hC000;
    tick(5);
    arst_n = 1'b1;
    tick();
    `CHK({sum_sel, dec_sel}, 4'h0)
    for (int i = 0; i < 4; i++) wr(BP[i], BA[i], BD[i]);
    wr(8'h04, 7'h08, 8'hE5);
    for (int i = 0; i < 4; i++) begin
      bq_rd_idx = BI[i];
      tick(2);
      `CHK(bq_rd_data, BD[i])
    end
    // summing code 11 is reserved, so the host side never writes it
    for (int s = 0; s < 6; s++) begin
      mix_enable = s[0];
      restart({4'h0, 2'(s >> 1), 2'b00});
      for (int i = 0; i < NCH_IN; i++)
        `CHK(out_frame.ch[i], expect_ch(2'(s >> 1), i))
    end
    mix_enable = 1'b0;
    for (int d = 0; d < 3; d++) begin
      restart({2'b00, 2'(d), 4'h0});
      mod_data[0] = 24'h000100;
      la[d] = 0;
      do begin frames(1); la[d]++; end
        while (out_frame.ch[0] !== 24'h000100 && la[d] < 40);
      mod_data = XS;
    end
    `CHK(la[0] - la[1], LIN_DELAY - LOW_DELAY)
    `CHK(la[1] - la[2], LOW_DELAY - ULTRA_DELAY)
    // one partial frame plus the output register frame add two to the depth
    `CHK(la[0], LIN_DELAY + 2)
    pdm_select = 1'b1;
    restart(8'h00);
    `CHK(out_frame.ch[0][SMP_W-1], 1'b0)
    `CHK(out_frame.ch[1][SMP_W-1], 1'b1)
    report_and_stop();
  end
endmodule // rcs_record_path_tb

/* File: inc/rcs_pkg.sv */
package rcs_pkg;
  // sample and coefficient widths, channel and mixer counts
  localparam int SMP_W = 24;
  localparam int COEF_W = 16;
  localparam int NCH_IN = 6;
  localparam int NMIX = 4;
  localparam int NMIX_SRC = 4;

  // biquad coefficient storage: 12 sections x 20 registers on pages 2 and 3
  localparam int BQ_SECTIONS = 12;
  localparam int BQ_REGS_PER_SECT = 20;
  localparam int BQ_SECT_PER_PAGE = 6;
  localparam logic [7:0] BQ_PAGE_LO = 8'h02;
  localparam logic [7:0] BQ_PAGE_HI = 8'h03;
  localparam logic [6:0] BQ_REG_FIRST = 7'h08;
  localparam logic [6:0] BQ_REG_LAST = 7'h7F;
  localparam int BQ_WORDS = BQ_SECTIONS * BQ_REGS_PER_SECT;

  // page 0 register 107 field layout
  localparam logic [7:0] CFG_PAGE = 8'h00;
  localparam logic [6:0] CFG_REG = 7'h6B;
  localparam int SUM_LSB = 2;
  localparam int DEC_LSB = 4;

  typedef enum logic [1:0] {
    SUM_OFF  = 2'b00,
    SUM_PAIR = 2'b01,
    SUM_QUAD = 2'b10,
    SUM_RSVD = 2'b11
  } rcs_sum_t;

  typedef enum logic [1:0] {
    DEC_LINEAR = 2'b00,
    DEC_LOWLAT = 2'b01,
    DEC_ULTRA  = 2'b10,
    DEC_RSVD   = 2'b11
  } rcs_dec_t;

  // decimation: oversampling ratio and the linear-phase delay line depth
  // giving roughly 17.1 output periods of group delay
  localparam int OSR = 64;
  localparam int LIN_DELAY = 17;
  localparam int LOW_DELAY = 4;
  localparam int ULTRA_DELAY = 1;

  typedef struct packed {
    logic [7:0] page;
    logic [6:0] addr;
    logic [7:0] data;
    logic       wr;
  } rcs_cfg_wr_t;

  typedef struct packed {
    logic                           valid;
    logic [NCH_IN-1:0][SMP_W-1:0]   ch;
  } rcs_frame_t;
endpackage

/* File: rtl/rcs_record_path.sv */
module rcs_record_path
  import rcs_pkg::*;
#(
  parameter int OVERSAMPLE = OSR,
  parameter int LIN_DEPTH  = LIN_DELAY
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  // configuration writes
  input  wire rcs_cfg_wr_t                   cfg_wr,
  // mixer scale factors, signed Q1.15 per mixer and source
  input  wire logic [NMIX-1:0][NMIX_SRC-1:0][COEF_W-1:0] mix_gain,
  input  wire logic                          mix_enable,
  // modulator input: one signed word per channel per oversampled tick
  input  wire logic                          mod_valid,
  input  wire logic [NCH_IN-1:0][SMP_W-1:0]  mod_data,
  // pdm microphone input, already in clock domain
  input  wire logic                          pdm_select,
  input  wire logic [NCH_IN-1:0]             pdm_bits,
  // frame sync pin
  input  wire logic                          frame_sync,
  // output frame and status
  output rcs_frame_t                         out_frame,
  output logic [1:0]                         channel_sum_select,
  output logic [1:0]                         decimation_type_select,
  // coefficient readback
  input  wire logic [$clog2(BQ_WORDS)-1:0]   bq_rd_idx,
  output logic [7:0]                         bq_rd_data
);

  localparam int ACC_W = SMP_W + $clog2(OVERSAMPLE) + 1;
  localparam int IDX_W = $clog2(BQ_WORDS);
  localparam int DL_W  = $clog2(LIN_DEPTH + 1);

  typedef struct packed {
    logic [1:0]                              fs_sync;
    logic                                    fs_prev;
    logic [1:0]                              sum_sel;
    logic [1:0]                              dec_sel;
    logic [BQ_WORDS-1:0][7:0]                bq;
    logic [NCH_IN-1:0][ACC_W-1:0]            acc;
    logic [LIN_DEPTH-1:0][NCH_IN-1:0][SMP_W-1:0] dline;
    logic                                    oval;
    logic [NCH_IN-1:0][SMP_W-1:0]            ochan;
    logic [7:0]                              rd;
  } rcs_state_t;

  rcs_state_t st_ff;
  rcs_state_t nxt_st;

  // decimator outputs, one raw sample per channel
  logic [NCH_IN-1:0][SMP_W-1:0]            dec_smp;
  logic [NCH_IN-1:0][SMP_W-1:0]            delayed;
  logic [NCH_IN-1:0][SMP_W-1:0]            summed;
  logic [NCH_IN-1:0][SMP_W-1:0]            mixed;
  logic                                    fs_rise;
  logic [IDX_W-1:0]                        wr_idx;
  logic                                    wr_bq;
  logic [7:0]                              page_ofs;
  logic [SMP_W+1:0]                        s4;
  logic [SMP_W:0]                          s2;
  logic [SMP_W+COEF_W+2:0]                 macc;
  logic [SMP_W-1:0]                        in_smp;
  int                                      dsel;

  always_comb begin
    nxt_st  = st_ff;
    dec_smp = '0;
    delayed = '0;
    summed  = '0;
    mixed   = '0;
    s4      = '0;
    s2      = '0;
    macc    = '0;
    in_smp  = '0;
    dsel    = 0;
    wr_bq   = 1'b0;
    wr_idx  = '0;
    page_ofs = '0;

    // pin passes two flops before the edge detector sees it
    nxt_st.fs_sync = {st_ff.fs_sync[0], frame_sync};
    nxt_st.fs_prev = st_ff.fs_sync[1];
    fs_rise = st_ff.fs_sync[1] & ~st_ff.fs_prev;

    // control register write
    if (cfg_wr.wr && cfg_wr.page == CFG_PAGE && cfg_wr.addr == CFG_REG) begin
      nxt_st.sum_sel = cfg_wr.data[SUM_LSB +: 2];
      nxt_st.dec_sel = cfg_wr.data[DEC_LSB +: 2];
    end

    // coefficient storage, section k at register 8 + 20*(k mod 6)
    if (cfg_wr.wr && cfg_wr.addr >= BQ_REG_FIRST &&
        (cfg_wr.page == BQ_PAGE_LO || cfg_wr.page == BQ_PAGE_HI)) begin
      page_ofs = (cfg_wr.page == BQ_PAGE_HI) ?
                 8'(BQ_SECT_PER_PAGE * BQ_REGS_PER_SECT) : 8'h00;
      wr_idx = IDX_W'(page_ofs + 8'(cfg_wr.addr - BQ_REG_FIRST));
      wr_bq  = 1'b1;
    end
    if (wr_bq)
      nxt_st.bq[wr_idx] = cfg_wr.data;
    nxt_st.rd = st_ff.bq[bq_rd_idx];

    // integrate-and-dump decimator; pdm bits map to +/- full scale
    for (int c = 0; c < NCH_IN; c++) begin
      if (pdm_select)
        in_smp = pdm_bits[c] ? {1'b0, {(SMP_W-1){1'b1}}}
                             : {1'b1, {(SMP_W-1){1'b0}}};
      else
        in_smp = mod_data[c];
      dec_smp[c] = SMP_W'(st_ff.acc[c] >>> $clog2(OVERSAMPLE));
      if (fs_rise)
        nxt_st.acc[c] = (mod_valid | pdm_select) ?
                        ACC_W'(signed'(in_smp)) : '0;
      else if (mod_valid | pdm_select)
        nxt_st.acc[c] = st_ff.acc[c] + ACC_W'(signed'(in_smp));
    end

    // filter type sets the depth of the output delay line; one shared
    // linear response serves every rate family, including 8k and 7.35k
    case (rcs_dec_t'(st_ff.dec_sel))
      DEC_LINEAR: dsel = LIN_DEPTH - 1;
      DEC_LOWLAT: dsel = LOW_DELAY - 1;
      DEC_ULTRA:  dsel = ULTRA_DELAY - 1;
      default:    dsel = LIN_DEPTH - 1;
    endcase
    if (fs_rise) begin
      nxt_st.dline[0] = dec_smp;
      for (int i = 1; i < LIN_DEPTH; i++)
        nxt_st.dline[i] = st_ff.dline[i-1];
    end
    delayed = st_ff.dline[dsel];

    // channel summing, equal weights, sign extended then shifted
    summed = delayed;
    case (rcs_sum_t'(st_ff.sum_sel))
      SUM_PAIR: begin
        for (int p = 0; p < NCH_IN; p += 2) begin
          s2 = {delayed[p][SMP_W-1], delayed[p]} +
               {delayed[p+1][SMP_W-1], delayed[p+1]};
          summed[p]   = SMP_W'(signed'(s2) >>> 1);
          summed[p+1] = SMP_W'(signed'(s2) >>> 1);
        end
      end
      SUM_QUAD: begin
        s4 = {{2{delayed[0][SMP_W-1]}}, delayed[0]} +
             {{2{delayed[1][SMP_W-1]}}, delayed[1]} +
             {{2{delayed[2][SMP_W-1]}}, delayed[2]} +
             {{2{delayed[3][SMP_W-1]}}, delayed[3]};
        for (int q = 0; q < 4; q++)
          summed[q] = SMP_W'(signed'(s4) >>> 2);
      end
      // reserved code is never written by the host; treat as pass-through
      default: summed = delayed;
    endcase

    // mixers: only when summing is off, sources are inputs 1 to 4
    mixed = summed;
    if (mix_enable && st_ff.sum_sel == SUM_OFF) begin
      for (int m = 0; m < NMIX; m++) begin
        macc = '0;
        for (int k = 0; k < NMIX_SRC; k++)
          macc = macc + (SMP_W+COEF_W+3)'(
                 signed'(delayed[k]) * signed'(mix_gain[m][k]));
        mixed[m] = SMP_W'(signed'(macc) >>> (COEF_W - 1));
      end
    end

    // output register updates once per frame
    nxt_st.oval = fs_rise;
    if (fs_rise)
      nxt_st.ochan = mixed;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign out_frame.valid          = st_ff.oval;
  assign out_frame.ch             = st_ff.ochan;
  assign channel_sum_select       = st_ff.sum_sel;
  assign decimation_type_select   = st_ff.dec_sel;
  assign bq_rd_data               = st_ff.rd;

endmodule // rcs_record_path
